// File: bench/host_master.sv
// host model: commands, password bits and scratchpad copy bytes
`default_nettype none
module host_master
	import guard_pkg::*;
(
	// clock
	input wire logic clk,
	// towards the guard
	output cmd_req_t cmd_req,
	output logic pw_bit_valid,
	output logic pw_bit,
	output copy_byte_t copy_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************
	// idle levels
	// ************************************************
	initial begin
		cmd_req = '0;
		pw_bit_valid = 1'b0;
		pw_bit = 1'b0;
		copy_byte = '0;
	end
	// command code, then password bits back to back when guarded
	task automatic send(input cmd_t kind, input logic [7:0] prm,
		input logic [63:0] pw, input logic guarded);
		@(posedge clk);
		cmd_req <= '{1'b1, kind, prm};
		if (guarded) begin
			for (int i = 0; i < 64; i++) begin
				@(posedge clk);
				cmd_req.valid <= 1'b0;
				pw_bit_valid <= 1'b1;
				// bit 0 first, bit 63 last
				pw_bit <= pw[i];
			end
		end
		@(posedge clk);
		cmd_req.valid <= 1'b0;
		pw_bit_valid <= 1'b0;
		// a released line must not keep showing the last bit
		pw_bit <= ~pw[63];
		// verdict, then the idle cycle before the next request
		repeat (3) @(posedge clk);
	endtask : send
	// one byte of the scratchpad copy
	task automatic copy(input logic [9:0] addr, input logic [7:0] data);
		@(posedge clk);
		copy_byte <= '{1'b1, addr, data};
		@(posedge clk);
		copy_byte <= '{1'b0, ~addr, ~data};
	endtask : copy
endmodule : host_master
`default_nettype wire

// File: bench/tb_logger_guard.sv
// self-checking bench of the counter and password guard
`default_nettype none
module tb_logger_guard
	import guard_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************
	// signals
	// ************************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	cmd_req_t cmd_req;
	logic pw_bit_valid;
	logic pw_bit;
	copy_byte_t copy_byte;
	logic wake_measure = 1'b0;
	logic wake_alarm_test = 1'b0;
	logic alarm_seen = 1'b0;
	logic alarm_start_mode = 1'b0;
	logic [9:0] rd_addr = 10'h000;
	logic [7:0] rd_data;
	logic cmd_grant;
	logic cmd_deny;
	logic mission_running_flag;
	int n_fail = 0;
	int checks_done = 0;
	logic [1:0] exp_q[$]; // expected {grant, deny}
	logic [31:0] lfsr_r = 32'h518f;
	logic [63:0] rpw;
	logic [63:0] fpw;
	// 125 MHz clock
	always #4 clk = ~clk;
	host_master host (.clk(clk), .cmd_req(cmd_req),
		.pw_bit_valid(pw_bit_valid), .pw_bit(pw_bit), .copy_byte(copy_byte));
	logger_guard DUT (.clk(clk), .rst_n(rst_n), .cmd_req(cmd_req),
		.pw_bit_valid(pw_bit_valid), .pw_bit(pw_bit), .copy_byte(copy_byte),
		.wake_measure(wake_measure), .wake_alarm_test(wake_alarm_test),
		.alarm_seen(alarm_seen), .alarm_start_mode(alarm_start_mode),
		.rd_addr(rd_addr), .rd_data(rd_data), .cmd_grant(cmd_grant),
		.cmd_deny(cmd_deny), .mission_running_flag(mission_running_flag));
	// ************************************************
	// helpers
	// ************************************************
	task automatic check(input string w, input logic [31:0] s,
		input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", w, e, s);
		end
	endtask : check
	// random passwords from the shift register
	function automatic logic [63:0] rnd();
		logic [31:0] a;
		a = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		lfsr_r = {a[30:0], a[31] ^ a[21] ^ a[1] ^ a[0]};
		return {lfsr_r, a};
	endfunction : rnd
	// note the verdict, then let the host send
	task automatic cmd(input cmd_t k, input logic [7:0] p,
		input logic [63:0] pw, input logic [1:0] e);
		exp_q.push_back(e);
		host.send(k, p, pw, k != scratchpad_cmd && k != forced_conversion_cmd);
	endtask : cmd
	task automatic rd(input logic [9:0] a, input logic [7:0] e, string w);
		@(posedge clk);
		rd_addr <= a;
		@(posedge clk);
		#1 check(w, {24'h0, rd_data}, {24'h0, e});
	endtask : rd
	// three count bytes, lsb at the lowest address
	task automatic rd3(input logic [9:0] a, input logic [23:0] e, string w);
		for (int i = 0; i < 3; i++) begin
			rd(a + 10'(i), e[8*i +: 8], w);
		end
	endtask : rd3
	task automatic wake(input logic test);
		@(posedge clk);
		wake_alarm_test <= test;
		wake_measure <= ~test;
		@(posedge clk);
		wake_alarm_test <= 1'b0;
		wake_measure <= 1'b0;
	endtask : wake
	task automatic flag(input logic e);
		check("flag", {31'h0, mission_running_flag}, {31'h0, e});
	endtask : flag
	task automatic tally_and_finish();
		check("pending", exp_q.size(), 32'h0);
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// ************************************************
	// verdict watcher: oldest note against each verdict
	// ************************************************
	always @(posedge clk) begin
		if ((cmd_grant | cmd_deny) === 1'b1) begin
			check("verdict", {cmd_grant, cmd_deny}, exp_q.pop_front());
		end
	end
	// watchdog, far beyond the expected run
	initial begin
		#60000;
		n_fail++;
		tally_and_finish();
	end
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		rpw = rnd();
		fpw = rnd();
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(variant_addr, variant_default, "variant");
		rd(pw_enable_addr, 8'h00, "enable");
		// checking off: any password passes
		cmd(start_mission_cmd, 8'h00, ~fpw, 2'b10);
		flag(1'b1);
		repeat (3) wake(1'b0);
		rd3(mission_cnt_addr, 24'h3, "mission");
		rd3(lifetime_cnt_addr, 24'h3, "lifetime");
		cmd(stop_mission_cmd, 8'h00, rpw, 2'b10);
		flag(1'b0);
		// enable byte and both passwords in one transfer
		cmd(scratchpad_cmd, 8'h00, 64'h0, 2'b10);
		cmd(copy_scratchpad_cmd, 8'h00, rpw, 2'b10);
		host.copy(pw_enable_addr, pw_on_code);
		for (int i = 0; i < 8; i++) begin
			host.copy(read_pw_addr + 10'(i), rpw[8*i +: 8]);
			host.copy(full_pw_addr + 10'(i), fpw[8*i +: 8]);
		end
		cmd(scratchpad_cmd, 8'h00, 64'h0, 2'b10);
		rd(read_pw_addr, 8'h00, "read pw");
		rd(pw_page_end, 8'h00, "full pw");
		// checking on
		cmd(read_memory_cmd, 8'h00, rpw ^ 64'h1, 2'b01);
		cmd(read_memory_cmd, 8'h00, rpw, 2'b10);
		cmd(forced_conversion_cmd, 8'h00, 64'h0, 2'b10);
		cmd(copy_scratchpad_cmd, 8'h00, fpw ^ {1'b1, 63'h0}, 2'b01);
		host.copy(pw_enable_addr, 8'h00);
		rd(pw_enable_addr, pw_on_code, "enable");
		cmd(memory_clear_cmd, 8'h02, fpw, 2'b10);
		rd3(mission_cnt_addr, 24'h3, "mission");
		cmd(memory_clear_cmd, clear_param, rpw, 2'b01);
		rd3(mission_cnt_addr, 24'h3, "mission");
		cmd(memory_clear_cmd, clear_param, fpw, 2'b10);
		rd3(mission_cnt_addr, 24'h0, "mission");
		cmd(start_mission_cmd, 8'h00, rpw, 2'b01);
		flag(1'b0);
		alarm_start_mode <= 1'b1;
		cmd(start_mission_cmd, 8'h00, fpw, 2'b10);
		// copy granted in mission, but the bytes must not land
		cmd(copy_scratchpad_cmd, 8'h00, fpw, 2'b10);
		host.copy(pw_enable_addr, 8'h00);
		host.copy(full_pw_addr, ~fpw[7:0]);
		rd(pw_enable_addr, pw_on_code, "enable");
		// alarm tests until the alarm, then logging
		repeat (2) wake(1'b1);
		alarm_seen <= 1'b1;
		@(posedge clk);
		alarm_seen <= 1'b0;
		wake(1'b0);
		// alarm test after the alarm: lifetime only
		wake(1'b1);
		cmd(memory_clear_cmd, clear_param, fpw, 2'b10);
		rd3(mission_cnt_addr, 24'h3, "mission");
		rd3(lifetime_cnt_addr, 24'h7, "lifetime");
		cmd(stop_mission_cmd, 8'h00, fpw, 2'b10);
		// full password must still be the one set before the mission
		cmd(read_memory_cmd, 8'h00, fpw, 2'b10);
		tally_and_finish();
	end
endmodule : tb_logger_guard
`default_nettype wire

// File: src/guard_pkg.sv
// package: addresses, codes and carrier types of the counter/password guard
`default_nettype none
package guard_pkg;
	// ************************************************
	// register addresses
	// ************************************************
	localparam logic [9:0] mission_cnt_addr = 10'h220; // three bytes, lsb low
	localparam logic [9:0] lifetime_cnt_addr = 10'h223; // three bytes, lsb low
	localparam logic [9:0] variant_addr = 10'h226; // identification byte
	localparam logic [9:0] pw_enable_addr = 10'h227; // enable byte
	localparam logic [9:0] read_pw_addr = 10'h228; // eight bytes
	localparam logic [9:0] full_pw_addr = 10'h230; // eight bytes
	localparam logic [9:0] pw_page_end = 10'h237; // last password byte
	// ************************************************
	// codes and values
	// ************************************************
	localparam logic [7:0] pw_on_code = 8'haa; // checking enabled
	localparam logic [7:0] clear_param = 8'h01; // memory clear parameter
	localparam logic [7:0] variant_default = 8'h5a; // arbitrary value
	localparam logic [23:0] count_max = 24'hffffff; // counter ceiling
	localparam logic [23:0] count_zero = 24'h000000;
	localparam logic [63:0] pw_zero = 64'h0;
	localparam logic [7:0] byte_zero = 8'h00;
	localparam logic [5:0] pw_last_bit = 6'h3f; // bit 63 of a password
	localparam logic [5:0] bit_zero = 6'h00;
	// ************************************************
	// command kinds
	// ************************************************
	typedef enum logic [2:0] {
		read_memory_cmd = 3'h0,
		copy_scratchpad_cmd = 3'h1,
		memory_clear_cmd = 3'h2,
		start_mission_cmd = 3'h3,
		stop_mission_cmd = 3'h4,
		forced_conversion_cmd = 3'h5,
		scratchpad_cmd = 3'h6
	} cmd_t;
	// command request from the protocol layer
	typedef struct packed {
		logic valid; // one-cycle start of a command
		cmd_t kind; // command decoded from the code byte
		logic [7:0] param; // parameter byte (memory clear)
	} cmd_req_t;
	// one byte copied from the scratchpad to a register location
	typedef struct packed {
		logic valid; // one-cycle strobe
		logic [9:0] addr;
		logic [7:0] data;
	} copy_byte_t;
endpackage : guard_pkg
`default_nettype wire

// File: src/logger_guard.sv
// counters, identification byte and two-level password guard
// How it works
// (RULE_01) mission count, 24 bits, counts measure wakes
// (RULE_02) memory clear zeroes the mission count
// (RULE_03) mission count read at 0220h, lsb first
// (RULE_04) lifetime count counts measure and alarm-test wakes
// (RULE_05) lifetime count 24 bits at 0223h, saturates
// (RULE_06) fixed identification byte at 0226h
// (RULE_07) scratchpad and forced conversion pass unchecked
// (RULE_08) password follows the command code byte
// (RULE_09) checking on only when enable byte is aah
// (RULE_10) with checking on, changes need full password
// (RULE_11) enable byte read-only during a mission
// (RULE_12) read password arrives bit 0 first
// (RULE_13) read memory granted if off or matched
// (RULE_14) full password arrives bit 0 first
// (RULE_15) guarded commands run if off or matched
// (RULE_16) password bytes read back as zero
// (RULE_17) no password change during a mission
// (RULE_18) passwords written through scratchpad copy path
// (RULE_19) host writes enable and passwords together
// (RULE_20) host verifies scratchpad before the copy
// (RULE_21) host overwrites scratchpad after the copy
// (RULE_22) passwords at 0228h and 0230h, bit 0 low
// (RULE_23) mission flag high while mission runs
// (RULE_24) memory clear needs parameter byte 01h
// (RULE_25) alarm-start mode tests until alarm then logs
// (RULE_26) mismatch aborts with no state change
`default_nettype none
module logger_guard
	import guard_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// command and password bit stream
	input wire cmd_req_t cmd_req,
	input wire logic pw_bit_valid,
	input wire logic pw_bit,
	// scratchpad copy into the register page
	input wire copy_byte_t copy_byte,
	// timebase wake events and mode
	input wire logic wake_measure,
	input wire logic wake_alarm_test,
	input wire logic alarm_seen,
	input wire logic alarm_start_mode,
	// register read port
	input wire logic [9:0] rd_addr,
	output logic [7:0] rd_data,
	// verdicts and state
	output logic cmd_grant,
	output logic cmd_deny,
	output logic mission_running_flag
);
	// ************************************************
	// state
	// ************************************************
	typedef enum logic [2:0] {
		st_idle = 3'b001, // waiting for a command
		st_pw = 3'b010, // shifting in the password
		st_done = 3'b100 // verdict issued
	} st_t;
	st_t st_r, st_nxt;
	cmd_t kind_r, kind_nxt; // command under check
	logic [7:0] param_r, param_nxt;
	logic [63:0] rx_pw_r, rx_pw_nxt; // received password
	logic [5:0] bit_r, bit_nxt; // received bit count
	logic [23:0] mission_cnt_r, mission_cnt_nxt;
	logic [23:0] lifetime_cnt_r, lifetime_cnt_nxt;
	logic [7:0] pw_enable_byte_r, pw_enable_byte_nxt;
	logic [63:0] read_pw_r, read_pw_nxt;
	logic [63:0] full_pw_r, full_pw_nxt;
	logic mission_r, mission_nxt;
	logic waiting_alarm_r, waiting_alarm_nxt; // alarm-start wait
	logic grant_r, grant_nxt, deny_r, deny_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic copy_armed_r, copy_armed_nxt; // copy was granted
	logic checking; // enable byte is aah
	logic [63:0] full_rx; // final received word
	logic pass_ok; // password check result
	logic [2:0] lane; // byte lane within a password
	// ************************************************
	// guard decision
	// ************************************************
	// (RULE_09) checking only on exact code
	assign checking = (pw_enable_byte_r == pw_on_code);
	// (RULE_12) bit 0 first: shift in from the top
	assign full_rx = {pw_bit, rx_pw_r[63:1]};
	// (RULE_13) read memory accepts either password
	always_comb begin
		pass_ok = 1'b0;
		if (!checking)
			pass_ok = 1'b1;
		else if (kind_r == read_memory_cmd)
			pass_ok = (full_rx == read_pw_r) || (full_rx == full_pw_r);
		else
			// (RULE_15) full password for other guards
			pass_ok = (full_rx == full_pw_r);
	end
	assign lane = copy_byte.addr[2:0];
	// ************************************************
	// next state of guard, counters and registers
	// ************************************************
	always_comb begin
		st_nxt = st_r;
		kind_nxt = kind_r;
		param_nxt = param_r;
		rx_pw_nxt = rx_pw_r;
		bit_nxt = bit_r;
		mission_cnt_nxt = mission_cnt_r;
		lifetime_cnt_nxt = lifetime_cnt_r;
		pw_enable_byte_nxt = pw_enable_byte_r;
		read_pw_nxt = read_pw_r;
		full_pw_nxt = full_pw_r;
		mission_nxt = mission_r;
		waiting_alarm_nxt = waiting_alarm_r;
		grant_nxt = 1'b0;
		deny_nxt = 1'b0;
		copy_armed_nxt = copy_armed_r;
		// (RULE_25) alarm ends the wait, logging begins
		// cleared first so a start granted this cycle sets it again
		if (mission_r && waiting_alarm_r && alarm_seen)
			waiting_alarm_nxt = 1'b0;
		case (st_r)
			st_idle: begin
				if (cmd_req.valid) begin
					kind_nxt = cmd_req.kind;
					param_nxt = cmd_req.param;
					bit_nxt = bit_zero;
					// (RULE_07) unguarded commands granted at once
					if (cmd_req.kind == scratchpad_cmd ||
						cmd_req.kind == forced_conversion_cmd) begin
						grant_nxt = 1'b1;
						// a scratchpad or forced conversion command ends any armed copy
						copy_armed_nxt = 1'b0;
					end else begin
						// (RULE_08) password follows the code byte
						st_nxt = st_pw;
					end
				end
			end
			st_pw: begin
				if (pw_bit_valid) begin
					rx_pw_nxt = full_rx;
					bit_nxt = bit_r + 6'h01;
					// (RULE_14) verdict after bit 63
					if (bit_r == pw_last_bit) begin
						st_nxt = st_done;
						if (pass_ok) begin
							grant_nxt = 1'b1;
							case (kind_r)
								copy_scratchpad_cmd: copy_armed_nxt = 1'b1;
								memory_clear_cmd: begin
									// (RULE_24) clear only with 01h
									// (RULE_02) zero the mission count
									if (param_r == clear_param && !mission_r)
										mission_cnt_nxt = count_zero;
								end
								start_mission_cmd: begin
									// (RULE_23) flag rises on start
									mission_nxt = 1'b1;
									waiting_alarm_nxt = alarm_start_mode;
								end
								stop_mission_cmd: mission_nxt = 1'b0;
								default: ;
							endcase
						end else begin
							// (RULE_26) abort, nothing changes
							deny_nxt = 1'b1;
						end
					end
				end
			end
			st_done: begin
				st_nxt = st_idle;
				rx_pw_nxt = pw_zero; // do not keep the secret
			end
			default: st_nxt = st_idle;
		endcase
		// (RULE_01) count wakes that measure for the mission
		if (mission_r && (wake_measure ||
			(waiting_alarm_r && wake_alarm_test)))
			mission_cnt_nxt = mission_cnt_r + 24'h000001;
		// (RULE_04) lifetime counts both wake kinds
		// (RULE_05) hold at the ceiling
		if (mission_r && (wake_measure || wake_alarm_test) &&
			lifetime_cnt_r != count_max)
			lifetime_cnt_nxt = lifetime_cnt_r + 24'h000001;
		// (RULE_18) copied bytes land in the password page
		// (RULE_17) no change during a mission
		// (RULE_10) copy was granted, so full password matched or checking off
		if (copy_byte.valid && copy_armed_r && !mission_r) begin
			// (RULE_11) enable byte frozen in a mission
			if (copy_byte.addr == pw_enable_addr)
				pw_enable_byte_nxt = copy_byte.data;
			// (RULE_22) bit 0 of a password in lowest byte
			else if (copy_byte.addr >= read_pw_addr &&
				copy_byte.addr < full_pw_addr)
				read_pw_nxt[lane*8 +: 8] = copy_byte.data;
			else if (copy_byte.addr >= full_pw_addr &&
				copy_byte.addr <= pw_page_end)
				full_pw_nxt[lane*8 +: 8] = copy_byte.data;
		end
	end
	// ************************************************
	// read port
	// ************************************************
	// (RULE_03) byte lanes lsb at the lowest address
	always_comb begin
		rd_nxt = byte_zero;
		case (rd_addr)
			mission_cnt_addr: rd_nxt = mission_cnt_r[7:0];
			mission_cnt_addr + 10'h1: rd_nxt = mission_cnt_r[15:8];
			mission_cnt_addr + 10'h2: rd_nxt = mission_cnt_r[23:16];
			lifetime_cnt_addr: rd_nxt = lifetime_cnt_r[7:0];
			lifetime_cnt_addr + 10'h1: rd_nxt = lifetime_cnt_r[15:8];
			lifetime_cnt_addr + 10'h2: rd_nxt = lifetime_cnt_r[23:16];
			// (RULE_06) fixed variant code
			variant_addr: rd_nxt = variant_default;
			pw_enable_addr: rd_nxt = pw_enable_byte_r;
			// (RULE_16) passwords read as zero by default
			default: rd_nxt = byte_zero;
		endcase
	end
	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= st_idle;
			kind_r <= read_memory_cmd;
			param_r <= byte_zero;
			rx_pw_r <= pw_zero;
			bit_r <= bit_zero;
			mission_cnt_r <= count_zero;
			lifetime_cnt_r <= count_zero;
			pw_enable_byte_r <= byte_zero;
			read_pw_r <= pw_zero;
			full_pw_r <= pw_zero;
			mission_r <= 1'b0;
			waiting_alarm_r <= 1'b0;
			grant_r <= 1'b0;
			deny_r <= 1'b0;
			rd_r <= byte_zero;
			copy_armed_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			kind_r <= kind_nxt;
			param_r <= param_nxt;
			rx_pw_r <= rx_pw_nxt;
			bit_r <= bit_nxt;
			mission_cnt_r <= mission_cnt_nxt;
			lifetime_cnt_r <= lifetime_cnt_nxt;
			pw_enable_byte_r <= pw_enable_byte_nxt;
			read_pw_r <= read_pw_nxt;
			full_pw_r <= full_pw_nxt;
			mission_r <= mission_nxt;
			waiting_alarm_r <= waiting_alarm_nxt;
			grant_r <= grant_nxt;
			deny_r <= deny_nxt;
			rd_r <= rd_nxt;
			copy_armed_r <= copy_armed_nxt;
		end
	end
	assign rd_data = rd_r;
	assign cmd_grant = grant_r;
	assign cmd_deny = deny_r;
	assign mission_running_flag = mission_r;
	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_deny_keeps_mission: assert property ( // (RULE_26)
		deny_r |-> mission_r == $past(mission_r))
		else $error("mission state changed on a denied command");
	chk_unchecked_grant: assert property ( // (RULE_07)
		st_r == st_idle && cmd_req.valid &&
		cmd_req.kind == forced_conversion_cmd |=> grant_r)
		else $error("forced conversion not granted at once");
	chk_pw_reads_zero: assert property ( // (RULE_16)
		rd_addr >= read_pw_addr && rd_addr <= pw_page_end |=>
		rd_r == byte_zero)
		else $error("password byte readable");
	chk_lifetime_ceiling: assert property ( // (RULE_05)
		lifetime_cnt_r == count_max |=> lifetime_cnt_r == count_max)
		else $error("lifetime count wrapped");
	chk_enable_frozen: assert property ( // (RULE_11)
		mission_r |=> pw_enable_byte_r == $past(pw_enable_byte_r))
		else $error("enable byte changed in a mission");
	chk_open_guard: assert property ( // (RULE_09)
		st_r == st_pw && pw_bit_valid && bit_r == pw_last_bit &&
		!checking |=> grant_r && !deny_r)
		else $error("command refused with checking off");
	chk_mission_count: assert property ( // (RULE_01)
		mission_r && wake_measure && st_r == st_idle &&
		!cmd_req.valid |=>
		mission_cnt_r == $past(mission_cnt_r) + 24'h000001)
		else $error("mission count missed a wake");
	chk_clear_zero: assert property ( // (RULE_02)
		grant_r && kind_r == memory_clear_cmd &&
		param_r == clear_param && !$past(mission_r) |->
		mission_cnt_r == count_zero)
		else $error("memory clear left count");
	cov_deny: cover property (deny_r);
	cov_start: cover property (!mission_r ##1 mission_r);
	cov_copy: cover property (copy_byte.valid && copy_armed_r);
endmodule : logger_guard
`default_nettype wire
